// [src/status_event_summary_regs.svh]
// Constants of the status and event summary unit: bit positions,
// reset values and default error codes.
// Assumes inclusion by bare name from the design file.
`ifndef STATUS_EVENT_SUMMARY_REGS_SVH
`define STATUS_EVENT_SUMMARY_REGS_SVH

// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define EVT_OPC_BIT 0
`define EVT_QUERY_ERR_BIT 2
`define EVT_DEV_ERR_BIT 3
`define EVT_EXEC_ERR_BIT 4
`define EVT_CMD_ERR_BIT 5
`define EVT_USER_REQ_BIT 6
`define EVT_POWER_ON_BIT 7
`define EVT_USED_MASK 8'hfd

// ----------------------------------------------------------------
// Operation status bits
// ----------------------------------------------------------------
`define OPR_ALIGN_BIT 0
`define OPR_SWEEP_BIT 3
`define OPR_MEAS_BIT 4
`define OPR_TRIG_WAIT_BIT 5
`define OPR_HARDCOPY_BIT 8
`define OPR_SCAN_RES_BIT 9
`define OPR_RANGE_DONE_BIT 10
`define OPR_THRESH_BIT 13
`define OPR_USED_MASK 16'h2739

// ----------------------------------------------------------------
// Status byte and reset values
// ----------------------------------------------------------------
`define STB_ESB_BIT 5
`define PPE_RESET 8'h00
`define ESE_RESET 8'h00
`define SEF_RESET 8'h80

// ----------------------------------------------------------------
// Default error codes
// ----------------------------------------------------------------
`define ERR_DEV_DEFAULT 16'hfed4
`define ERR_EXEC_DEFAULT 16'hff38
`define ERR_CMD_DEFAULT 16'hff9c

`endif

// [src/status_event_summary_pkg.sv]
// Types of the status and event summary unit.
// Assumes the command decoder in front of it uses these codes.
package status_event_summary_pkg;

	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_IST_QUERY,
		CMD_PPE_WRITE,
		CMD_PPE_QUERY,
		CMD_ESE_WRITE,
		CMD_ESE_QUERY,
		CMD_SEF_QUERY,
		CMD_OPR_QUERY,
		CMD_OPC
	} cmd_e;

	typedef enum logic [1:0] {
		OPC_IDLE,
		OPC_WAIT
	} opc_state_e;

endpackage

// [src/status_event_summary_unit.sv]
// Status byte summary, event status and operation status logic.
// Assumes a command decoder on clk that presents one command per cycle,
// and activity levels from the instrument core that may be asynchronous.
`include "status_event_summary_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module status_event_summary_unit (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] cmd,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic [7:0] stb_other,
	input wire logic ppoll_req,
	input wire logic exec_idle,
	input wire logic read_no_query,
	input wire logic unread_overrun,
	input wire logic dev_err,
	input wire logic [15:0] dev_err_code,
	input wire logic exec_err,
	input wire logic cmd_err,
	input wire logic go_local,
	input wire logic alignment_running,
	input wire logic sweep_active,
	input wire logic measurement_active,
	input wire logic trig_armed,
	input wire logic hardcopy_busy,
	input wire logic continuous_result_feed,
	input wire logic scan_block_ready,
	input wire logic range_done,
	input wire logic resume_scan_command,
	input wire logic threshold_active,
	output logic [7:0] resp_data,
	output logic resp_valid,
	output logic ist,
	output logic ppoll_resp,
	output logic esb,
	output logic err_push,
	output logic [15:0] err_code
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Activity levels come from other domains; three stages, level taken when stages 2 and 3 agree
	localparam int NS = 8;
	logic [NS-1:0] async_in;
	logic [NS-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
	logic [NS-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_lvl;

	assign async_in = {threshold_active, range_done, scan_block_ready,
		hardcopy_busy, trig_armed, measurement_active, sweep_active,
		alignment_running};

	always_comb begin
		nxt_s1 = async_in;
		nxt_s2 = s1_ff;
		nxt_s3 = s2_ff;
		nxt_lvl = lvl_ff;
		for (int i = 0; i < NS; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_lvl[i] = s3_ff[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_ff <= 8'h00;
			s2_ff <= 8'h00;
			s3_ff <= 8'h00;
			lvl_ff <= 8'h00;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
			lvl_ff <= nxt_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Event status, enables and operation complete
	// ----------------------------------------------------------------
	logic [7:0] sef_ff, nxt_sef;
	logic [7:0] ese_ff, nxt_ese;
	logic [7:0] ppe_ff, nxt_ppe;
	status_event_summary_pkg::opc_state_e opc_ff, nxt_opc;
	logic [7:0] evt_set;
	logic sef_read;

	assign sef_read = cmd_valid &&
		cmd == 4'(status_event_summary_pkg::CMD_SEF_QUERY);

	always_comb begin
		nxt_opc = opc_ff;
		evt_set = 8'h00;
		case (opc_ff)
			status_event_summary_pkg::OPC_IDLE: begin
				if (cmd_valid &&
					cmd == 4'(status_event_summary_pkg::CMD_OPC)) begin
					nxt_opc = status_event_summary_pkg::OPC_WAIT;
				end
			end
			default: begin
				if (exec_idle) begin
					evt_set[`EVT_OPC_BIT] = 1'b1;
					nxt_opc = status_event_summary_pkg::OPC_IDLE;
				end
			end
		endcase
		evt_set[`EVT_QUERY_ERR_BIT] = read_no_query | unread_overrun;
		evt_set[`EVT_DEV_ERR_BIT] = dev_err;
		evt_set[`EVT_EXEC_ERR_BIT] = exec_err;
		evt_set[`EVT_CMD_ERR_BIT] = cmd_err;
		evt_set[`EVT_USER_REQ_BIT] = go_local;
		// Reading clears, but a simultaneous event survives
		nxt_sef = (sef_read ? 8'h00 : sef_ff) | evt_set;
		nxt_sef = nxt_sef & `EVT_USED_MASK;
		nxt_ese = ese_ff;
		nxt_ppe = ppe_ff;
		if (cmd_valid &&
			cmd == 4'(status_event_summary_pkg::CMD_ESE_WRITE)) begin
			nxt_ese = cmd_data;
		end
		if (cmd_valid &&
			cmd == 4'(status_event_summary_pkg::CMD_PPE_WRITE)) begin
			nxt_ppe = cmd_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sef_ff <= `SEF_RESET;
			ese_ff <= `ESE_RESET;
			ppe_ff <= `PPE_RESET;
			opc_ff <= status_event_summary_pkg::OPC_IDLE;
		end else begin
			sef_ff <= nxt_sef;
			ese_ff <= nxt_ese;
			ppe_ff <= nxt_ppe;
			opc_ff <= nxt_opc;
		end
	end

	// ----------------------------------------------------------------
	// Error queue push
	// ----------------------------------------------------------------
	logic nxt_err_push;
	logic [15:0] nxt_err_code;

	always_comb begin
		nxt_err_push = dev_err | exec_err | cmd_err;
		nxt_err_code = err_code;
		// Priority when several strike together: command over others
		if (cmd_err) begin
			nxt_err_code = `ERR_CMD_DEFAULT;
		end else if (exec_err) begin
			nxt_err_code = `ERR_EXEC_DEFAULT;
		end else if (dev_err) begin
			nxt_err_code = dev_err_code;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			err_push <= 1'b0;
			err_code <= 16'h0000;
		end else begin
			err_push <= nxt_err_push;
			err_code <= nxt_err_code;
		end
	end

	// ----------------------------------------------------------------
	// Operation status: live levels OR latched since last read
	// ----------------------------------------------------------------
	logic [15:0] opr_live, opr_hist_ff, nxt_opr_hist, opr_view;
	logic scan_q_ff, range_q_ff;
	logic scan_rise, range_rise, range_flag_ff, nxt_range_flag;
	logic opr_read;

	assign opr_read = cmd_valid &&
		cmd == 4'(status_event_summary_pkg::CMD_OPR_QUERY);
	assign scan_rise = lvl_ff[5] & ~scan_q_ff;
	assign range_rise = lvl_ff[6] & ~range_q_ff;

	always_comb begin
		opr_live = 16'h0000;
		opr_live[`OPR_ALIGN_BIT] = lvl_ff[0];
		opr_live[`OPR_SWEEP_BIT] = lvl_ff[1] | lvl_ff[2];
		opr_live[`OPR_MEAS_BIT] = lvl_ff[1] | lvl_ff[2];
		opr_live[`OPR_TRIG_WAIT_BIT] = lvl_ff[3];
		opr_live[`OPR_HARDCOPY_BIT] = lvl_ff[4];
		opr_live[`OPR_SCAN_RES_BIT] = scan_rise & continuous_result_feed;
		opr_live[`OPR_RANGE_DONE_BIT] = range_flag_ff;
		opr_live[`OPR_THRESH_BIT] = lvl_ff[7];
		nxt_range_flag = range_flag_ff;
		if (resume_scan_command) begin
			nxt_range_flag = 1'b0;
		end
		if (range_rise) begin
			nxt_range_flag = 1'b1;
		end
		// history cleared on read, new activity kept
		nxt_opr_hist = (opr_read ? 16'h0000 : opr_hist_ff) | opr_live;
		opr_view = (opr_live | opr_hist_ff) & `OPR_USED_MASK;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			opr_hist_ff <= 16'h0000;
			scan_q_ff <= 1'b0;
			range_q_ff <= 1'b0;
			range_flag_ff <= 1'b0;
		end else begin
			opr_hist_ff <= nxt_opr_hist;
			scan_q_ff <= lvl_ff[5];
			range_q_ff <= lvl_ff[6];
			range_flag_ff <= nxt_range_flag;
		end
	end

	// ----------------------------------------------------------------
	// Status byte summary, IST and query answers
	// ----------------------------------------------------------------
	logic nxt_esb, nxt_ist, nxt_ppoll, nxt_resp_valid;
	logic [7:0] stb_view, nxt_resp;

	always_comb begin
		nxt_esb = |(nxt_sef & nxt_ese);
		stb_view = stb_other;
		stb_view[`STB_ESB_BIT] = esb;
		nxt_ist = |(stb_view & ppe_ff);
		nxt_ppoll = ppoll_req & nxt_ist;
		nxt_resp_valid = 1'b0;
		nxt_resp = resp_data;
		if (cmd_valid) begin
			nxt_resp_valid = 1'b1;
			case (cmd)
				4'(status_event_summary_pkg::CMD_IST_QUERY):
					nxt_resp = {7'h00, ist};
				4'(status_event_summary_pkg::CMD_PPE_QUERY):
					nxt_resp = ppe_ff;
				4'(status_event_summary_pkg::CMD_ESE_QUERY):
					nxt_resp = ese_ff;
				4'(status_event_summary_pkg::CMD_SEF_QUERY):
					nxt_resp = sef_ff;
				4'(status_event_summary_pkg::CMD_OPR_QUERY):
					nxt_resp = opr_view[7:0];
				default:
					nxt_resp_valid = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			esb <= 1'b0;
			ist <= 1'b0;
			ppoll_resp <= 1'b0;
			resp_valid <= 1'b0;
			resp_data <= 8'h00;
		end else begin
			esb <= nxt_esb;
			ist <= nxt_ist;
			ppoll_resp <= nxt_ppoll;
			resp_valid <= nxt_resp_valid;
			resp_data <= nxt_resp;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_ist_mask;
		@(posedge clk) disable iff (!rstn)
		ist == |($past(stb_view) & $past(ppe_ff));
	endproperty
	a_ist_mask: assert property (p_ist_mask)
		else $error("ist not masked status OR");

	property p_ppoll;
		@(posedge clk) disable iff (!rstn)
		ppoll_resp |-> ist;
	endproperty
	a_ppoll: assert property (p_ppoll)
		else $error("poll answer without ist");

	property p_ppe_wr;
		@(posedge clk) disable iff (!rstn)
		cmd_valid && cmd == 4'(status_event_summary_pkg::CMD_PPE_WRITE)
		|=> ppe_ff == $past(cmd_data);
	endproperty
	a_ppe_wr: assert property (p_ppe_wr)
		else $error("poll mask not written");

	property p_esb;
		@(posedge clk) disable iff (!rstn)
		|(sef_ff & ese_ff) |-> esb;
	endproperty
	a_esb: assert property (p_esb)
		else $error("event summary missing");

	property p_ese_wr;
		@(posedge clk) disable iff (!rstn)
		cmd_valid && cmd == 4'(status_event_summary_pkg::CMD_ESE_WRITE)
		|=> ese_ff == $past(cmd_data);
	endproperty
	a_ese_wr: assert property (p_ese_wr)
		else $error("enable mask not written");

	property p_sef_q;
		@(posedge clk) disable iff (!rstn)
		sef_read |=> resp_valid && resp_data == $past(sef_ff);
	endproperty
	a_sef_q: assert property (p_sef_q)
		else $error("event query answer wrong");

	property p_opc;
		@(posedge clk) disable iff (!rstn)
		opc_ff == status_event_summary_pkg::OPC_WAIT && exec_idle
		|=> sef_ff[`EVT_OPC_BIT];
	endproperty
	a_opc: assert property (p_opc)
		else $error("operation complete not set");

	property p_cmd_err;
		@(posedge clk) disable iff (!rstn)
		cmd_err |=> sef_ff[`EVT_CMD_ERR_BIT] && err_push;
	endproperty
	a_cmd_err: assert property (p_cmd_err)
		else $error("command error not recorded");

	property p_opr_zero;
		@(posedge clk) disable iff (!rstn)
		opr_view[15] == 1'b0 && sef_ff[1] == 1'b0;
	endproperty
	a_opr_zero: assert property (p_opr_zero)
		else $error("unused status bit set");

	property p_sweep_pair;
		@(posedge clk) disable iff (!rstn)
		opr_view[`OPR_SWEEP_BIT] == opr_view[`OPR_MEAS_BIT];
	endproperty
	a_sweep_pair: assert property (p_sweep_pair)
		else $error("sweep bits differ");

	property p_scan_feed;
		@(posedge clk) disable iff (!rstn)
		opr_live[`OPR_SCAN_RES_BIT] |-> continuous_result_feed;
	endproperty
	a_scan_feed: assert property (p_scan_feed)
		else $error("scan bit without result feed");

	property p_range_hold;
		@(posedge clk) disable iff (!rstn)
		range_flag_ff && !resume_scan_command |=> range_flag_ff;
	endproperty
	a_range_hold: assert property (p_range_hold)
		else $error("range flag dropped before resume");

	c_opc: cover property (@(posedge clk) disable iff (!rstn)
		opc_ff == status_event_summary_pkg::OPC_WAIT ##[1:20]
		sef_ff[`EVT_OPC_BIT]);
	c_esb: cover property (@(posedge clk) disable iff (!rstn) $rose(esb));
	c_ppoll: cover property (@(posedge clk) disable iff (!rstn)
		ppoll_resp);

endmodule

`default_nettype wire

// [dv/remote_controller_model.sv]
// Remote controller model: issues commands, feed enable and resume.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
`default_nettype none

module remote_controller_model (
	input wire logic clk,
	output logic [3:0] cmd,
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	output logic continuous_result_feed,
	output logic resume_scan_command
);
	initial begin
		cmd = 4'h0;
		cmd_valid = 1'b0;
		cmd_data = 8'h5a;
		continuous_result_feed = 1'b0;
		resume_scan_command = 1'b0;
	end

	// Released lines are scrambled so stale values never look valid
	task automatic send(input logic [3:0] c, input logic [7:0] d);
		@(negedge clk);
		cmd <= c;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		@(negedge clk);
		cmd_valid <= 1'b0;
		cmd <= ~c;
		cmd_data <= ~d;
	endtask

	task automatic feed(input logic en);
		@(negedge clk);
		continuous_result_feed <= en;
	endtask

	task automatic resume();
		@(negedge clk);
		resume_scan_command <= 1'b1;
		@(negedge clk);
		resume_scan_command <= 1'b0;
	endtask
endmodule

`default_nettype wire

// [dv/status_event_summary_unit_tb.sv]
// Self-checking bench with an expected-answer queue and a monitor.
// Assumes the controller model drives the command port.
`timescale 1ns/1ps
`default_nettype none

module status_event_summary_unit_tb;
	logic clk, rstn, ppoll_req, exec_idle, esb, ist, ppoll_resp;
	logic cmd_valid, resp_valid, err_push, feed, resume, e;
	logic [3:0] cmd;
	logic [5:0] ev;
	logic [7:0] cmd_data, stb_other, lv, resp_data, s, p;
	logic [15:0] dev_code, err_code;
	logic [7:0] exp_q[$];
	logic [15:0] err_q[$];
	int error_cnt = 0;
	int compares = 0;
	int bt[6] = '{2, 2, 3, 4, 5, 6};

	remote_controller_model remote_controller_model_inst (.clk(clk),
		.cmd(cmd), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
		.continuous_result_feed(feed), .resume_scan_command(resume));

	status_event_summary_unit status_event_summary_unit_inst (
		.clk(clk), .rstn(rstn), .cmd(cmd), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .stb_other(stb_other), .ppoll_req(ppoll_req),
		.exec_idle(exec_idle), .read_no_query(ev[0]),
		.unread_overrun(ev[1]), .dev_err(ev[2]), .dev_err_code(dev_code),
		.exec_err(ev[3]), .cmd_err(ev[4]), .go_local(ev[5]),
		.alignment_running(lv[0]), .sweep_active(lv[1]),
		.measurement_active(lv[2]), .trig_armed(lv[3]),
		.hardcopy_busy(lv[4]), .continuous_result_feed(feed),
		.scan_block_ready(lv[5]), .range_done(lv[6]),
		.resume_scan_command(resume), .threshold_active(lv[7]),
		.resp_data(resp_data), .resp_valid(resp_valid), .ist(ist),
		.ppoll_resp(ppoll_resp), .esb(esb), .err_push(err_push),
		.err_code(err_code));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(string n, logic [15:0] x, logic [15:0] v);
		compares++;
		if (v !== x) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, x, v);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic q(logic [3:0] c, logic [7:0] x);
		exp_q.push_back(x);
		remote_controller_model_inst.send(c, 8'($urandom));
	endtask

	task automatic w(logic [3:0] c, logic [7:0] d);
		remote_controller_model_inst.send(c, d);
	endtask

	task automatic pulse(int i);
		@(negedge clk);
		ev[i] <= 1'b1;
		@(negedge clk);
		ev[i] <= 1'b0;
	endtask

	task automatic finish_test();
		if (exp_q.size() != 0 || err_q.size() != 0)
			error_cnt++;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Monitor: each answer takes the oldest expectation
	// ------------------------------------------------------------
	always @(negedge clk) begin
		if (resp_valid === 1'b1)
			chk("resp_data", exp_q.size() ? exp_q.pop_front() : 'x, resp_data);
		if (err_push === 1'b1)
			chk("err_code", err_q.size() ? err_q.pop_front() : 'x, err_code);
	end

	// Span covers every test with wide margin
	initial begin
		#100us;
		error_cnt++;
		finish_test();
	end

	initial begin
		rstn = 1'b0;
		ppoll_req = 1'b0;
		exec_idle = 1'b0;
		ev = 6'h00;
		stb_other = 8'h00;
		lv = 8'h00;
		dev_code = 16'hfed4;
		void'($urandom(62));
		repeat (16) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		q(status_event_summary_pkg::CMD_SEF_QUERY, 8'h80);
		q(status_event_summary_pkg::CMD_SEF_QUERY, 8'h00);
		$display("done power on");
		for (int i = 0; i < 4; i++) begin
			s = 8'($urandom);
			w(status_event_summary_pkg::CMD_ESE_WRITE, s);
			q(status_event_summary_pkg::CMD_ESE_QUERY, s);
			s = 8'($urandom);
			w(status_event_summary_pkg::CMD_PPE_WRITE, s);
			q(status_event_summary_pkg::CMD_PPE_QUERY, s);
		end
		w(status_event_summary_pkg::CMD_ESE_WRITE, 8'h00);
		$display("done masks");
		for (int i = 0; i < 6; i++) begin
			dev_code = 16'hfe71 + 16'($urandom_range(0, 99));
			if (i == 2)
				err_q.push_back(dev_code);
			if (i == 3)
				err_q.push_back(16'hff38);
			if (i == 4)
				err_q.push_back(16'hff9c);
			pulse(i);
			cyc(2);
			q(status_event_summary_pkg::CMD_SEF_QUERY, 8'h01 << bt[i]);
		end
		$display("done events");
		w(status_event_summary_pkg::CMD_ESE_WRITE, 8'h10);
		w(status_event_summary_pkg::CMD_PPE_WRITE, 8'h20);
		cyc(3);
		chk("esb", 1'b0, esb);
		err_q.push_back(16'hff38);
		pulse(3);
		cyc(3);
		chk("esb", 1'b1, esb);
		chk("ist", 1'b1, ist);
		q(status_event_summary_pkg::CMD_SEF_QUERY, 8'h10);
		cyc(3);
		chk("esb", 1'b0, esb);
		$display("done summary");
		for (int i = 0; i < 8; i++) begin
			s = i ? 8'($urandom) : 8'h40;
			p = i ? 8'($urandom) : 8'h40;
			stb_other <= s;
			ppoll_req <= 1'($urandom);
			w(status_event_summary_pkg::CMD_PPE_WRITE, p);
			cyc(3);
			e = |({s[7:6], 1'b0, s[4:0]} & p);
			chk("ist", e, ist);
			chk("ppoll_resp", ppoll_req & e, ppoll_resp);
			q(status_event_summary_pkg::CMD_IST_QUERY, {7'h00, e});
		end
		$display("done ist");
		w(status_event_summary_pkg::CMD_ESE_WRITE, 8'h01);
		w(status_event_summary_pkg::CMD_OPC, 8'h00);
		cyc(6);
		chk("esb", 1'b0, esb);
		exec_idle <= 1'b1;
		cyc(3);
		chk("esb", 1'b1, esb);
		q(status_event_summary_pkg::CMD_SEF_QUERY, 8'h01);
		$display("done opc");
		remote_controller_model_inst.feed(1'b1);
		lv <= {4'($urandom), 4'h9};
		cyc(6);
		q(status_event_summary_pkg::CMD_OPR_QUERY, 8'h21);
		lv <= {4'($urandom), 4'h2};
		cyc(6);
		q(status_event_summary_pkg::CMD_OPR_QUERY, 8'h39);
		q(status_event_summary_pkg::CMD_OPR_QUERY, 8'h18);
		lv <= {4'($urandom), 4'h4};
		cyc(6);
		remote_controller_model_inst.resume();
		lv <= 8'h00;
		cyc(6);
		q(status_event_summary_pkg::CMD_OPR_QUERY, 8'h18);
		q(status_event_summary_pkg::CMD_OPR_QUERY, 8'h00);
		cyc(4);
		$display("done operation");
		finish_test();
	end
endmodule

`default_nettype wire
